// File: core/dvsa_top.v
// dvsa_top.v: vendor state word, polarity and mask registers, status bit 14
// assumes flag inputs synchronous to clk_in, object access port driven by the
// fieldbus stack with single-cycle requests
`timescale 1ns/100ps
`include "dvsa_defs.vh"

module dvsa_top #(
  parameter WIDTH = 32
) (
  input  wire             clk_in,
  input  wire             nrst_in,
  // flags from other drive functions
  input  wire             homing_done_in,
  input  wire             abs_encoder_in,
  input  wire             commut_valid_in,
  input  wire             fault_in,
  input  wire             dc_link_charged_in,
  input  wire             encoder_ready_in,
  input  wire             blocking_proc_in,
  input  wire             ctrl_enable_in,
  input  wire             traj_done_in,
  input  wire             torque_off_state_in,
  // object dictionary access
  input  wire             od_rd_in,
  input  wire             od_wr_in,
  input  wire [15:0]      od_index_in,
  input  wire [7:0]       od_subidx_in,
  input  wire [WIDTH-1:0] od_wdata_in,
  output reg  [WIDTH-1:0] od_rdata_out,
  output reg              od_ack_out,
  output reg              od_err_out,
  // process data and standard status word bit
  output reg  [WIDTH-1:0] state_word_out,
  output reg              status_bit14_out
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  reg rst_meta_q;
  reg rst_n_q;

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  localparam SEL_NONE  = 2'h0;
  localparam SEL_STATE = 2'h1;
  localparam SEL_MASK  = 2'h2;
  localparam SEL_POL   = 2'h3;

  function [1:0] od_decode;
    input [15:0] idx;
    input [7:0]  sub;
    begin
      if (sub != `DVSA_SUB_FIRST)
        od_decode = SEL_NONE;
      else if (idx == `DVSA_IDX_STATE_WORD)
        od_decode = SEL_STATE;
      else if (idx == `DVSA_IDX_SEL_MASK)
        od_decode = SEL_MASK;
      else if (idx == `DVSA_IDX_POLARITY)
        od_decode = SEL_POL;
      else
        od_decode = SEL_NONE;
    end
  endfunction

  wire [1:0] sel = od_decode(od_index_in, od_subidx_in);

  // ----------------------------------------
  // request strobes
  // ----------------------------------------
  wire req_any;
  wire wr_mask;
  wire wr_pol;

  assign req_any = od_rd_in | od_wr_in;
  // only the two rw objects get a write strobe; the state word has none
  assign wr_mask = od_wr_in & (sel == SEL_MASK);
  assign wr_pol  = od_wr_in & (sel == SEL_POL);

  // ----------------------------------------
  // flag conditions
  // ----------------------------------------
  // plain gates, so each bit is at most one level of logic ahead of its flop
  wire homed_cond;
  wire commut_cond;
  wire ready_cond;
  wire traj_cond;
  wire torque_cond;

  // either source counts as referenced
  assign homed_cond  = homing_done_in | abs_encoder_in;
  // no finished commutation search means not valid
  assign commut_cond = commut_valid_in;
  // every precondition met, enable the only thing missing
  assign ready_cond  = ~fault_in & dc_link_charged_in & encoder_ready_in
                       & ~blocking_proc_in & ~ctrl_enable_in;
  // generator completion only, never a position compare
  assign traj_cond   = traj_done_in;
  // reported for as long as the torque-off state lasts
  assign torque_cond = torque_off_state_in;

  // ----------------------------------------
  // vendor state word
  // ----------------------------------------
  reg  [WIDTH-1:0] state_d;
  reg  [WIDTH-1:0] mask_q;
  reg  [WIDTH-1:0] mask_d;
  reg  [WIDTH-1:0] pol_q;
  reg  [WIDTH-1:0] pol_d;
  wire             any_sel;

  always @* begin
    state_d = {WIDTH{1'b0}};
    // unlisted bits stay zero
    state_d[`DVSA_BIT_HOMED]      = homed_cond;
    state_d[`DVSA_BIT_COMMUT]     = commut_cond;
    state_d[`DVSA_BIT_READY_EN]   = ready_cond;
    state_d[`DVSA_BIT_TRAJ_DONE]  = traj_cond;
    state_d[`DVSA_BIT_TORQUE_OFF] = torque_cond;
  end

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  always @* begin
    mask_d = mask_q;
    pol_d  = pol_q;
    if (wr_mask)
      mask_d = od_wdata_in;
    if (wr_pol)
      pol_d = od_wdata_in;
  end

  always @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mask_q <= `DVSA_RST_SEL_MASK;
      pol_q  <= `DVSA_RST_POLARITY;
    end else begin
      mask_q <= mask_d;
      pol_q  <= pol_d;
    end
  end

  // ----------------------------------------
  // evaluation
  // ----------------------------------------
  // works on the registered word, so bit 14 follows the readable word one cycle later
  dvsa_eval #(
    .WIDTH (WIDTH)
  ) u_eval (
    .state_in    (state_word_out),
    .polarity_in (pol_q),
    .mask_in     (mask_q),
    .any_out     (any_sel)
  );

  always @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_word_out   <= {WIDTH{1'b0}};
      status_bit14_out <= 1'b0;
    end else begin
      state_word_out   <= state_d;
      // set or cleared afresh every cycle
      status_bit14_out <= any_sel;
    end
  end

  // ----------------------------------------
  // access answers
  // ----------------------------------------
  reg [WIDTH-1:0] rdata_d;
  reg             err_d;

  always @* begin
    rdata_d = {WIDTH{1'b0}};
    err_d   = 1'b0;
    case (sel)
      SEL_STATE: begin
        rdata_d = state_word_out;
        // write to a read-only object is refused
        err_d   = od_wr_in;
      end
      SEL_MASK:  rdata_d = mask_q;
      SEL_POL:   rdata_d = pol_q;
      default:   err_d   = 1'b1;
    endcase
  end

  always @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      od_rdata_out <= {WIDTH{1'b0}};
      od_ack_out   <= 1'b0;
      od_err_out   <= 1'b0;
    end else begin
      od_ack_out   <= req_any;
      od_err_out   <= req_any & err_d;
      od_rdata_out <= od_rd_in ? rdata_d : {WIDTH{1'b0}};
    end
  end

endmodule // dvsa_top

// File: core/dvsa_defs.vh
// dvsa_defs.vh: constants for the vendor status aggregator
// assumes inclusion by bare name from core/ design files
`ifndef DVSA_DEFS_VH
`define DVSA_DEFS_VH

// ----------------------------------------
// object dictionary addresses
// ----------------------------------------
`define DVSA_IDX_STATE_WORD   16'h2000
`define DVSA_IDX_SEL_MASK     16'h2005
`define DVSA_IDX_POLARITY     16'h200a
`define DVSA_SUB_FIRST        8'h01

// ----------------------------------------
// vendor state word bit positions
// ----------------------------------------
`define DVSA_BIT_HOMED        0
`define DVSA_BIT_COMMUT       1
`define DVSA_BIT_READY_EN     2
`define DVSA_BIT_TRAJ_DONE    3
`define DVSA_BIT_TORQUE_OFF   8

// ----------------------------------------
// reset values and standard status word position
// ----------------------------------------
`define DVSA_RST_SEL_MASK     32'h0000_0000
`define DVSA_RST_POLARITY     32'h0000_0000
`define DVSA_STD_STATUS_BIT   14

`endif

// File: core/dvsa_eval.v
// dvsa_eval.v: per-bit inversion and masking, then or-reduction
// assumes all inputs are registered in the caller; purely combinational
`timescale 1ns/100ps

module dvsa_eval #(
  parameter WIDTH = 32
) (
  input  wire [WIDTH-1:0] state_in,
  input  wire [WIDTH-1:0] polarity_in,
  input  wire [WIDTH-1:0] mask_in,
  output wire             any_out
);

  // ----------------------------------------
  // per-bit select chain
  // ----------------------------------------
  wire [WIDTH-1:0] sel_bits;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      // invert first, then mask
      assign sel_bits[g] = (state_in[g] ^ polarity_in[g]) & mask_in[g];
    end
  endgenerate

  // any survivor sets, none clears
  assign any_out = |sel_bits;

endmodule // dvsa_eval

// File: sim/dvsa_top_sva.sv
// dvsa_top_sva.sv: port-level checks for the vendor status aggregator
// assumes one clock domain and single-cycle od_* requests
`timescale 1ns/100ps
`include "dvsa_defs.vh"
module dvsa_top_sva #(
  parameter WIDTH = 32
) (
  input wire             clk_in,
  input wire             nrst_in,
  input wire             homing_done_in,
  input wire             abs_encoder_in,
  input wire             commut_valid_in,
  input wire             fault_in,
  input wire             dc_link_charged_in,
  input wire             encoder_ready_in,
  input wire             blocking_proc_in,
  input wire             ctrl_enable_in,
  input wire             traj_done_in,
  input wire             torque_off_state_in,
  input wire             od_rd_in,
  input wire             od_wr_in,
  input wire [15:0]      od_index_in,
  input wire [7:0]       od_subidx_in,
  input wire [WIDTH-1:0] od_wdata_in,
  input wire [WIDTH-1:0] od_rdata_out,
  input wire             od_ack_out,
  input wire             od_err_out,
  input wire [WIDTH-1:0] state_word_out,
  input wire             status_bit14_out
);
  // shadows of mask and polarity, so bit 14 can be judged from ports only
  reg  [1:0]       up_q;
  reg  [WIDTH-1:0] sm_q;
  reg  [WIDTH-1:0] sp_q;
  wire             sub_ok = od_subidx_in == `DVSA_SUB_FIRST;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      up_q <= 2'h0;
      sm_q <= {WIDTH{1'b0}};
      sp_q <= {WIDTH{1'b0}};
    end else begin
      if (up_q != 2'h3)
        up_q <= up_q + 2'h1;
      if (od_wr_in && sub_ok && od_index_in == `DVSA_IDX_SEL_MASK)
        sm_q <= od_wdata_in;
      if (od_wr_in && sub_ok && od_index_in == `DVSA_IDX_POLARITY)
        sp_q <= od_wdata_in;
    end
  end
  // internal reset lags release by two edges, so wait for it
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in || up_q != 2'h3);
  homed_bit_a: assert property (state_word_out[0] == $past(homing_done_in | abs_encoder_in))
    else $error("homed bit wrong");
  commut_bit_a: assert property (state_word_out[1] == $past(commut_valid_in))
    else $error("commutation bit wrong");
  ready_bit_a: assert property (state_word_out[2] == $past(!fault_in && dc_link_charged_in && encoder_ready_in
    && !blocking_proc_in && !ctrl_enable_in)) else $error("ready bit wrong");
  traj_bit_a: assert property (state_word_out[3] == $past(traj_done_in))
    else $error("trajectory bit wrong");
  torque_off_a: assert property (state_word_out[8] == $past(torque_off_state_in))
    else $error("torque off bit wrong");
  ro_write_a: assert property (od_wr_in && od_index_in == `DVSA_IDX_STATE_WORD |=> od_ack_out && od_err_out)
    else $error("state word write not refused");
  mask_read_a: assert property (od_rd_in && sub_ok && od_index_in == `DVSA_IDX_SEL_MASK |=>
    od_ack_out && !od_err_out && od_rdata_out == sm_q) else $error("mask read wrong");
  pol_read_a: assert property (od_rd_in && sub_ok && od_index_in == `DVSA_IDX_POLARITY |=>
    od_ack_out && !od_err_out && od_rdata_out == sp_q) else $error("polarity read wrong");
  bit14_eval_a: assert property (status_bit14_out == $past(|((state_word_out ^ sp_q) & sm_q)))
    else $error("status bit 14 wrong");
endmodule // dvsa_top_sva
bind dvsa_top dvsa_top_sva #(.WIDTH(WIDTH)) chk_i (.*);

// File: sim/dvsa_top_tb.sv
// dvsa_top_tb.sv: self-checking bench for the vendor status aggregator
// assumes core/ on the include path; the bench drives every port itself
`timescale 1ns/100ps
`include "dvsa_defs.vh"
module dvsa_top_tb;
  reg         clk = 1'b0;
  reg         nrst = 1'b0;
  reg  [9:0]  fl = 10'h000;
  reg         rd = 1'b0;
  reg         wr = 1'b0;
  reg  [15:0] idx = 16'h0000;
  reg  [7:0]  sub = 8'h00;
  reg  [31:0] wd = 32'h0000_0000;
  wire [31:0] rdat;
  wire [31:0] sw;
  wire        ack;
  wire        err;
  wire        b14;
  integer     n_fail = 0;
  integer     comparisons = 0;
  dvsa_top uut (.clk_in(clk), .nrst_in(nrst), .homing_done_in(fl[0]), .abs_encoder_in(fl[1]),
    .commut_valid_in(fl[2]), .fault_in(fl[3]), .dc_link_charged_in(fl[4]), .encoder_ready_in(fl[5]),
    .blocking_proc_in(fl[6]), .ctrl_enable_in(fl[7]), .traj_done_in(fl[8]), .torque_off_state_in(fl[9]),
    .od_rd_in(rd), .od_wr_in(wr), .od_index_in(idx), .od_subidx_in(sub), .od_wdata_in(wd),
    .od_rdata_out(rdat), .od_ack_out(ack), .od_err_out(err), .state_word_out(sw), .status_bit14_out(b14));
  initial begin
    forever #2 clk = ~clk;
  end
  task chk(input string what, input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // one-cycle request; answer lands one edge later
  task acc(input w, input [15:0] i, input [7:0] s, input [31:0] d, input e, input [31:0] r);
    begin
      rd = !w;
      wr = w;
      idx = i;
      sub = s;
      wd = d;
      @(posedge clk);
      #1;
      rd = 1'b0;
      wr = 1'b0;
      chk("ack", {31'h0, ack}, 32'h1);
      chk("err", {31'h0, err}, {31'h0, e});
      chk("rdata", rdat, r);
      // answer stands one cycle; the idle edge also keeps strobes from toggling twice in one step
      @(posedge clk);
      #1;
      chk("ack idle", {31'h0, ack}, 32'h0);
      chk("rdata idle", rdat, 32'h0);
    end
  endtask
  // two edges: state word, then bit 14
  task flg(input [9:0] p, input [31:0] e, input b);
    begin
      fl = p;
      repeat (2) @(posedge clk);
      #1;
      chk("state", sw, e);
      chk("bit14", {31'h0, b14}, {31'h0, b});
    end
  endtask
  task t_regs;
    begin
      acc(1'b0, `DVSA_IDX_SEL_MASK, 8'h01, 32'h0, 1'b0, 32'h0);
      acc(1'b0, `DVSA_IDX_POLARITY, 8'h01, 32'h0, 1'b0, 32'h0);
      flg(10'h3ff, 32'h0000_010b, 1'b0);
      acc(1'b1, `DVSA_IDX_STATE_WORD, 8'h01, 32'hffff_ffff, 1'b1, 32'h0);
      acc(1'b0, `DVSA_IDX_STATE_WORD, 8'h01, 32'h0, 1'b0, 32'h0000_010b);
      acc(1'b0, `DVSA_IDX_SEL_MASK, 8'h02, 32'h0, 1'b1, 32'h0);
      acc(1'b1, `DVSA_IDX_POLARITY, 8'h01, 32'h0000_0004, 1'b0, 32'h0);
      acc(1'b1, `DVSA_IDX_SEL_MASK, 8'h01, 32'h0000_0005, 1'b0, 32'h0);
      acc(1'b0, `DVSA_IDX_POLARITY, 8'h01, 32'h0, 1'b0, 32'h0000_0004);
    end
  endtask
  task t_flags;
    begin
      flg(10'h001, 32'h1, 1'b1);
      flg(10'h002, 32'h1, 1'b1);
      flg(10'h004, 32'h2, 1'b1);
      flg(10'h030, 32'h4, 1'b0);
      flg(10'h0b0, 32'h0, 1'b1);
      flg(10'h038, 32'h0, 1'b1);
      flg(10'h070, 32'h0, 1'b1);
      flg(10'h020, 32'h0, 1'b1);
      flg(10'h010, 32'h0, 1'b1);
      flg(10'h100, 32'h8, 1'b1);
      flg(10'h200, 32'h100, 1'b1);
      flg(10'h031, 32'h5, 1'b1);
    end
  endtask
  // mid-run reset: registers back to zero, word follows flags again
  task t_reset;
    begin
      nrst = 1'b0;
      @(posedge clk);
      #1;
      chk("rst state", sw, 32'h0);
      chk("rst bit14", {31'h0, b14}, 32'h0);
      nrst = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("state after rst", sw, 32'h0000_0005);
      acc(1'b0, `DVSA_IDX_SEL_MASK, 8'h01, 32'h0, 1'b0, 32'h0);
      acc(1'b0, `DVSA_IDX_POLARITY, 8'h01, 32'h0, 1'b0, 32'h0);
      flg(10'h031, 32'h5, 1'b0);
    end
  endtask
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    #20000;
    n_fail = n_fail + 1;
    summarize;
  end
  initial begin
    repeat (10) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_regs;
    t_flags;
    t_reset;
    summarize;
  end
endmodule // dvsa_top_tb
